// ==== core/file_ram.sv ====
/*
 * File register memory: one write port, one read port with registered data.
 * Assumes the reader waits one clock for read data.
 */
`timescale 1ns/10ps
module file_ram
	import flag_ops_pkg::*;
(
	input wire logic ref_clk, // Core clock
	input wire logic wr_en, // Write strobe
	input wire logic [flag_ops_pkg::FADDR_W-1:0] wr_addr, // Write address
	input wire logic [flag_ops_pkg::DATA_W-1:0] wr_data, // Write data
	input wire logic [flag_ops_pkg::FADDR_W-1:0] rd_addr, // Read address
	output logic [flag_ops_pkg::DATA_W-1:0] rd_data // Registered read data
);
	logic [DATA_W-1:0] mem [0:(1<<FADDR_W)-1];

	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// ==== core/flag_ops_core.sv ====
/*
 * Two-cycle instruction core: fetch, then execute. Executes bit set/clear,
 * bit test and skip, absolute jump, and file increment/decrement, which
 * together carry the flag shorthand operations and their two-word forms.
 * Assumes a program memory on the same clock that returns the word for
 * prog_addr combinationally during the fetch cycle.
 */
// Functional notes
// - Set bit 1 of status sets digit carry
// - Clear bit 2 of status clears zero
// - Set bit 2 of status sets zero
// - Skip-if-set on carry skips when one
// - Skip-if-clear on carry skips when zero
// - Skip-if-set on digit carry skips when one
// - Skip-if-clear on digit carry skips when zero
// - Zero flag tests skip per set/clear form
// - Taken branch loads 9-bit target into counter
// - Untaken branch skips jump word, continues after
// - Branch on carry: clear-test then jump
// - Branch on no carry: set-test then jump
// - Branch on digit carry: clear-test then jump
// - Branch on zero: clear-test then jump
// - Branch on nonzero: set-test then jump
// - Flag arithmetic second word runs only when flag set
// - Add carry: clear-test carry then increment
// - Subtract carry decrements only when carry one
// - Increment writes file plus one to destination
// - Increment/decrement update only the zero flag, unless status itself is the file destination
// - Jump loads its 9-bit operand into counter
`timescale 1ns/10ps
module flag_ops_core
	import flag_ops_pkg::*;
(
	input wire logic ref_clk, // Core clock, 250 MHz
	input wire logic rst, // Asynchronous reset, active high
	output logic [flag_ops_pkg::PC_W-1:0] prog_addr, // Program memory address
	input wire logic [flag_ops_pkg::INSTR_W-1:0] prog_data, // Program word
	output logic [flag_ops_pkg::DATA_W-1:0] status_flags, // Status register
	output logic [flag_ops_pkg::DATA_W-1:0] working_reg, // Working register
	output logic skip_pending, // Next word will be skipped
	output logic exec_strobe // Pulse: a word was executed or skipped
);
	import flag_ops_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State

	core_state_t state;
	core_state_t next_state;
	logic [PC_W-1:0] pc;
	logic [PC_W-1:0] next_pc;
	logic [INSTR_W-1:0] instr;
	logic skip;
	logic next_skip;
	logic [DATA_W-1:0] next_status;
	logic [DATA_W-1:0] next_work;

	decoded_t dec;
	logic [DATA_W-1:0] ram_rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Decode and operand selection

	op_decode u_decode (
		.instr(instr),
		.dec(dec)
	);

	wire logic in_exec;
	wire logic live;
	wire logic status_target;
	wire logic [DATA_W-1:0] operand;
	wire logic [DATA_W-1:0] bit_mask;
	wire logic tested_bit;
	wire logic is_bset;
	wire logic is_bclr;
	wire logic is_skc;
	wire logic is_sks;
	wire logic is_jump;
	wire logic is_inc;
	wire logic is_dec;
	wire logic is_step;
	wire logic [DATA_W-1:0] step_result;
	wire logic [DATA_W-1:0] bit_result;
	wire logic [DATA_W-1:0] result;
	wire logic file_write;
	wire logic work_write;
	wire logic ram_we;
	wire logic result_zero;

	assign in_exec = state == ST_EXECUTE;
	// A word under a pending skip only clears the skip and advances the counter
	assign live = in_exec && !skip;
	assign status_target = dec.faddr == STATUS_FLAGS_ADDR;
	assign operand = status_target ? status_flags : ram_rdata;
	assign bit_mask = ONE_BYTE << dec.bit_sel;
	assign tested_bit = operand[dec.bit_sel];

	assign is_bset = dec.kind == KIND_BIT_SET;
	assign is_bclr = dec.kind == KIND_BIT_CLEAR;
	assign is_skc = dec.kind == KIND_SKIP_IF_CLEAR;
	assign is_sks = dec.kind == KIND_SKIP_IF_SET;
	assign is_jump = dec.kind == KIND_JUMP;
	assign is_inc = dec.kind == KIND_INCREMENT;
	assign is_dec = dec.kind == KIND_DECREMENT;
	assign is_step = is_inc || is_dec;

	assign step_result = is_inc ? operand + ONE_BYTE : operand - ONE_BYTE;
	// Bit set/clear touch only the selected bit
	assign bit_result = is_bset ? (operand | bit_mask) : (operand & ~bit_mask);
	assign result = is_step ? step_result : bit_result;
	assign result_zero = step_result == ZERO_BYTE;

	assign file_write = live && (is_bset || is_bclr || (is_step && dec.dest_file));
	assign work_write = live && is_step && !dec.dest_file;
	assign ram_we = file_write && !status_target;

	////////////////////////////////////////////////////////////////////////////////
	// File registers; read issued during fetch from the incoming word

	wire logic [FADDR_W-1:0] rd_addr;

	assign rd_addr = prog_data[FADDR_LSB +: FADDR_W];

	file_ram u_ram (
		.ref_clk(ref_clk),
		.wr_en(ram_we),
		.wr_addr(dec.faddr),
		.wr_data(result),
		.rd_addr(rd_addr),
		.rd_data(ram_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		next_state = state;
		next_pc = pc;
		next_skip = skip;
		next_status = status_flags;
		next_work = working_reg;
		unique case (state)
			ST_FETCH: begin
				next_state = ST_EXECUTE;
			end
			ST_EXECUTE: begin
				next_state = ST_FETCH;
				next_pc = pc + PC_STEP;
				// A skipped word clears the pending skip and falls through
				next_skip = 1'b0;
				if (live) begin
					// Skip on carry, digit carry and zero tests
					if (is_sks && tested_bit) begin
						next_skip = 1'b1;
					end
					if (is_skc && !tested_bit) begin
						next_skip = 1'b1;
					end
					if (is_jump) begin
						next_pc = dec.target;
					end
					if (file_write && status_target) begin
						next_status = result;
					end
					if (work_write) begin
						next_work = result;
					end
					if (is_step) begin
						// Only zero changes; set wins over a write to status
						next_status[ZERO_BIT] = result_zero;
					end
				end
			end
		endcase
	end

	// Two-word branches and flag arithmetic: the test word above sets the skip
	// when the flag condition fails, so the jump or the inc/dec that follows
	// runs only when the condition holds.

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= ST_FETCH;
			pc <= PC_RESET;
			skip <= 1'b0;
			status_flags <= STATUS_RESET;
			working_reg <= WORK_RESET;
		end else begin
			state <= next_state;
			pc <= next_pc;
			skip <= next_skip;
			status_flags <= next_status;
			working_reg <= next_work;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			instr <= INSTR_RESET;
			exec_strobe <= 1'b0;
		end else begin
			if (state == ST_FETCH) begin
				instr <= prog_data;
			end
			exec_strobe <= in_exec;
		end
	end

	assign prog_addr = pc;
	assign skip_pending = skip;
endmodule

// ==== core/flag_ops_pkg.sv ====
/*
 * Shared constants and types for the small 12-bit instruction core that runs
 * flag set/clear, flag skip tests, two-word flag branches and flag arithmetic.
 * Assumes a single clock domain and a program memory answering on the same clock.
 */
package flag_ops_pkg;

	localparam int INSTR_W = 12;
	localparam int PC_W = 9;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 5;
	localparam int BITSEL_W = 3;

	// File address and bit positions of the status register
	localparam logic [FADDR_W-1:0] STATUS_FLAGS_ADDR = 5'h03;
	localparam int CARRY_BIT = 0;
	localparam int DIGIT_CARRY_BIT = 1;
	localparam int ZERO_BIT = 2;

	// Reset values
	localparam logic [PC_W-1:0] PC_RESET = 9'h000;
	localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
	localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
	localparam logic [INSTR_W-1:0] INSTR_RESET = 12'h000;

	// Opcode fields: bit ops in [11:8], jump in [11:9], file inc/dec in [11:6]
	localparam logic [3:0] BIT_CLEAR_CODE = 4'h4;
	localparam logic [3:0] BIT_SET_CODE = 4'h5;
	localparam logic [3:0] SKIP_IF_CLEAR_CODE = 4'h6;
	localparam logic [3:0] SKIP_IF_SET_CODE = 4'h7;
	localparam logic [2:0] JUMP_CODE = 3'h5;
	localparam logic [5:0] INCREMENT_CODE = 6'h0a;
	localparam logic [5:0] DECREMENT_CODE = 6'h03;

	// Field positions inside the instruction word
	localparam int FADDR_LSB = 0;
	localparam int BITSEL_LSB = 5;
	localparam int DEST_BIT = 5;
	localparam int BITOP_LSB = 8;
	localparam int JUMPOP_LSB = 9;
	localparam int FILEOP_LSB = 6;

	localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [PC_W-1:0] PC_STEP = 9'h001;

	typedef enum logic [2:0] {
		KIND_NOP = 3'h0,
		KIND_BIT_SET = 3'h1,
		KIND_BIT_CLEAR = 3'h2,
		KIND_SKIP_IF_CLEAR = 3'h3,
		KIND_SKIP_IF_SET = 3'h4,
		KIND_JUMP = 3'h5,
		KIND_INCREMENT = 3'h6,
		KIND_DECREMENT = 3'h7
	} op_kind_t;

	typedef struct packed {
		op_kind_t kind;
		logic [BITSEL_W-1:0] bit_sel;
		logic [FADDR_W-1:0] faddr;
		logic dest_file;
		logic [PC_W-1:0] target;
	} decoded_t;

	typedef enum logic [1:0] {
		ST_FETCH = 2'b01,
		ST_EXECUTE = 2'b10
	} core_state_t;

endpackage

// ==== core/op_decode.sv ====
/*
 * Combinational decoder from a 12-bit instruction word to a decoded record.
 * Assumes the word is stable for the whole execute cycle.
 */
`timescale 1ns/10ps
module op_decode
	import flag_ops_pkg::*;
(
	input wire logic [flag_ops_pkg::INSTR_W-1:0] instr, // Instruction word
	output flag_ops_pkg::decoded_t dec // Decoded fields
);
	wire logic [3:0] bit_code;
	wire logic [2:0] jump_code;
	wire logic [5:0] file_code;
	wire logic is_bset;
	wire logic is_bclr;
	wire logic is_skc;
	wire logic is_sks;
	wire logic is_jump;
	wire logic is_inc;
	wire logic is_dec;

	assign bit_code = instr[BITOP_LSB +: 4];
	assign jump_code = instr[JUMPOP_LSB +: 3];
	assign file_code = instr[FILEOP_LSB +: 6];
	assign is_bset = bit_code == BIT_SET_CODE;
	assign is_bclr = bit_code == BIT_CLEAR_CODE;
	assign is_skc = bit_code == SKIP_IF_CLEAR_CODE;
	assign is_sks = bit_code == SKIP_IF_SET_CODE;
	assign is_jump = jump_code == JUMP_CODE;
	assign is_inc = file_code == INCREMENT_CODE;
	assign is_dec = file_code == DECREMENT_CODE;

	assign dec.kind = is_bset ? KIND_BIT_SET :
		is_bclr ? KIND_BIT_CLEAR :
		is_skc ? KIND_SKIP_IF_CLEAR :
		is_sks ? KIND_SKIP_IF_SET :
		is_jump ? KIND_JUMP :
		is_inc ? KIND_INCREMENT :
		is_dec ? KIND_DECREMENT : KIND_NOP;
	assign dec.bit_sel = instr[BITSEL_LSB +: BITSEL_W];
	assign dec.faddr = instr[FADDR_LSB +: FADDR_W];
	assign dec.dest_file = instr[DEST_BIT];
	assign dec.target = instr[PC_W-1:0];
endmodule

// ==== testbench/flag_ops_props.sv ====
/*
 * Concurrent checks on the ports of flag_ops_core.
 * Assumes one clock domain and an asynchronous active-high reset.
 */
`timescale 1ns/10ps
module flag_ops_props
	import flag_ops_pkg::*;
(
	input wire logic ref_clk, // Core clock
	input wire logic rst, // Reset
	input wire logic [flag_ops_pkg::PC_W-1:0] prog_addr, // Program counter
	input wire logic [flag_ops_pkg::INSTR_W-1:0] prog_data, // Fetched word
	input wire logic [flag_ops_pkg::DATA_W-1:0] status_flags, // Status register
	input wire logic [flag_ops_pkg::DATA_W-1:0] working_reg, // Working register
	input wire logic skip_pending, // Skip armed
	input wire logic exec_strobe // Word done
);
	wire [2:0] bsel = prog_data[7:5];
	wire sense = prog_data[8];
	wire [8:0] jmp_k = prog_data[8:0];
	wire [6:0] other_flags = {status_flags[7:3], status_flags[1:0]};
	wire on_status = prog_data[4:0] == STATUS_FLAGS_ADDR;
	wire is_skip = prog_data[11:9] == 3'h3;
	wire is_jump = prog_data[11:9] == JUMP_CODE;
	wire is_file = prog_data[11:6] == INCREMENT_CODE || prog_data[11:6] == DECREMENT_CODE;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Word fetched in the strobe cycle will really execute
	sequence s_run;
		exec_strobe && !skip_pending;
	endsequence
	sequence s_gap;
		!exec_strobe ##1 exec_strobe;
	endsequence
	chk_strobe_period: assert property (exec_strobe |=> s_gap)
		else $error("strobe spacing wrong");
	chk_pc_hold: assert property ($changed(prog_addr) |-> exec_strobe)
		else $error("counter moved outside a word end");
	chk_jump_load: assert property (s_run ##0 is_jump |-> ##2 prog_addr == $past(jmp_k, 2))
		else $error("jump target not loaded");
	chk_step_next: assert property (s_run ##0 !is_jump |-> ##2 prog_addr == $past(prog_addr, 2) + PC_STEP)
		else $error("counter did not step by one");
	chk_skip_noop: assert property (exec_strobe && skip_pending |-> ##2
		status_flags == $past(status_flags, 2) && working_reg == $past(working_reg, 2) &&
		prog_addr == $past(prog_addr, 2) + PC_STEP && !skip_pending)
		else $error("skipped word had an effect");
	chk_bit_set: assert property (s_run ##0 (prog_data[11:8] == BIT_SET_CODE && on_status) |->
		##2 status_flags == ($past(status_flags, 2) | (8'h01 << $past(bsel, 2))))
		else $error("status bit set wrong");
	chk_bit_clear: assert property (s_run ##0 (prog_data[11:8] == BIT_CLEAR_CODE && on_status) |->
		##2 status_flags == ($past(status_flags, 2) & ~(8'h01 << $past(bsel, 2))))
		else $error("status bit clear wrong");
	chk_skip_arm: assert property (s_run ##0 (is_skip && on_status) |->
		##2 skip_pending == (status_flags[$past(bsel, 2)] == $past(sense, 2)))
		else $error("skip decision wrong");
	chk_skip_idle: assert property (s_run ##0 !is_skip |-> ##2 !skip_pending)
		else $error("skip armed by a plain word");
	chk_file_flags: assert property (s_run ##0 (is_file && !(on_status && prog_data[5])) |->
		##2 other_flags == $past(other_flags, 2))
		else $error("inc or dec touched a non-zero flag");
	chk_zero_from_w: assert property (s_run ##0 (is_file && !prog_data[5]) |->
		##2 status_flags[ZERO_BIT] == (working_reg == ZERO_BYTE))
		else $error("zero flag does not match result");
endmodule

// ==== testbench/prog_rom.sv ====
/*
 * Program memory model: 512 twelve-bit words read combinationally.
 * Assumes the bench fills the array while the core is held in reset.
 */
`timescale 1ns/10ps
module prog_rom
	import flag_ops_pkg::*;
(
	input wire logic [flag_ops_pkg::PC_W-1:0] prog_addr, // Word address
	output logic [flag_ops_pkg::INSTR_W-1:0] prog_data // Word at that address
);
	logic [INSTR_W-1:0] rom [2**PC_W];
	assign prog_data = rom[prog_addr];
endmodule

// ==== testbench/tb.sv ====
/*
 * Self-checking bench for flag_ops_core: loads short programs, runs them
 * from reset and checks status, working register and counter.
 * Assumes the program memory model answers combinationally.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb;
	import flag_ops_pkg::*;
	localparam logic [8:0] TGT = 9'h1a5;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [PC_W-1:0] prog_addr;
	logic [INSTR_W-1:0] prog_data;
	logic [DATA_W-1:0] status_flags;
	logic [DATA_W-1:0] working_reg;
	logic skip_pending;
	logic exec_strobe;
	int miscompares = 0;
	int n_compared = 0;
	int pc;
	flag_ops_core i_dut (.ref_clk(ref_clk), .rst(rst), .prog_addr(prog_addr),
		.prog_data(prog_data), .status_flags(status_flags), .working_reg(working_reg),
		.skip_pending(skip_pending), .exec_strobe(exec_strobe));
	prog_rom i_mem (.prog_addr(prog_addr), .prog_data(prog_data));
	initial forever #2 ref_clk = ~ref_clk;
	function automatic logic [11:0] bw(input logic [3:0] op, input int b,
		input logic [4:0] f = STATUS_FLAGS_ADDR);
		return {op, b[2:0], f};
	endfunction
	function automatic logic [11:0] fw(input logic [5:0] op, input logic d);
		return {op, d, 5'h07};
	endfunction
	// Core is held in reset for a full edge before the program is rewritten
	task begin_prog();
		@(posedge ref_clk);
		rst <= 1'b1;
		@(posedge ref_clk);
		pc = 0;
	endtask
	task put(input logic [11:0] w);
		i_mem.rom[pc] = w;
		pc++;
	endtask
	// Ends the program with a jump to itself, runs n words, checks state
	task run(input int n, input logic [7:0] es, input logic [7:0] ew,
		input logic [8:0] ep, input string t);
		int k;
		i_mem.rom[pc] = {JUMP_CODE, 9'(pc)};
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		k = 0;
		for (int c = 0; c < 400 && k < n; c++) begin
			@(posedge ref_clk);
			#1;
			if (exec_strobe === 1'b1) k++;
		end
		`CHK("strobes", n, k)
		`CHK("status", es, status_flags)
		`CHK("working", ew, working_reg)
		`CHK("counter", ep, prog_addr)
		$display("%s done", t);
	endtask
	task finish_test();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		begin_prog();
		put(bw(BIT_SET_CODE, 0));
		put(bw(BIT_SET_CODE, 1));
		put(bw(BIT_SET_CODE, 2));
		put(bw(BIT_CLEAR_CODE, 2));
		put(bw(BIT_SET_CODE, 2));
		put(bw(BIT_CLEAR_CODE, 0));
		run(6, 8'h06, 8'h00, 9'h006, "set_clear");
		for (int b = 0; b < 3; b++)
			for (int s = 0; s < 2; s++)
				for (int v = 0; v < 2; v++) begin
					begin_prog();
					put(bw(v ? BIT_SET_CODE : BIT_CLEAR_CODE, b));
					put(bw(s ? SKIP_IF_SET_CODE : SKIP_IF_CLEAR_CODE, b));
					put({JUMP_CODE, TGT});
					i_mem.rom[TGT] = {JUMP_CODE, TGT};
					run(3, 8'(1 << b) & {8{v[0]}}, 8'h00, (s != v) ? TGT : 9'h003,
						"branch");
				end
		begin_prog();
		for (int i = 0; i < 8; i++)
			put(bw(BIT_CLEAR_CODE, i, 5'h07));
		put(bw(BIT_SET_CODE, 0));
		put(bw(BIT_SET_CODE, 2));
		put(bw(SKIP_IF_CLEAR_CODE, 0));
		put(fw(DECREMENT_CODE, 1'b1));
		put(bw(SKIP_IF_CLEAR_CODE, 1));
		put(fw(INCREMENT_CODE, 1'b1));
		put(bw(SKIP_IF_CLEAR_CODE, 0));
		put(fw(INCREMENT_CODE, 1'b0));
		put(bw(BIT_CLEAR_CODE, 0));
		put(bw(BIT_SET_CODE, 1));
		put(bw(SKIP_IF_CLEAR_CODE, 1));
		put(fw(DECREMENT_CODE, 1'b0));
		put(bw(SKIP_IF_CLEAR_CODE, 0));
		put(fw(INCREMENT_CODE, 1'b0));
		run(22, 8'h02, 8'hfe, 9'h016, "flag_arith");
		// Increment back into the file, then a skip test on a plain file bit
		begin_prog();
		for (int i = 0; i < 8; i++)
			put(bw(BIT_CLEAR_CODE, i, 5'h07));
		put(bw(BIT_SET_CODE, 1));
		put(bw(SKIP_IF_CLEAR_CODE, 1));
		put(fw(INCREMENT_CODE, 1'b1));
		put(fw(INCREMENT_CODE, 1'b0));
		put(bw(SKIP_IF_SET_CODE, 0, 5'h07));
		put(bw(BIT_SET_CODE, 2));
		run(14, 8'h02, 8'h02, 9'h00e, "inc_to_file");
		finish_test();
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		miscompares++;
		$display("watchdog expired");
		finish_test();
	end
endmodule
bind flag_ops_core flag_ops_props i_props (.ref_clk(ref_clk), .rst(rst),
	.prog_addr(prog_addr), .prog_data(prog_data), .status_flags(status_flags),
	.working_reg(working_reg), .skip_pending(skip_pending), .exec_strobe(exec_strobe));
